/* File: hw/ipcb_pkg.sv */
package ipcb_pkg;

    // ****************************************************************
    // bus and register geometry
    // ****************************************************************
    localparam int IPCB_DATA_W   = 32;
    localparam int IPCB_ADDR_W   = 3;
    localparam int IPCB_BE_W     = 4;
    localparam int IPCB_REG_W    = 16;
    localparam int IPCB_NUM_REGS = 6;
    localparam int IPCB_NUM_SRC  = 19;

    // word index of each register (byte address is four times this)
    localparam logic [2:0] IPCB_IDX_CFG_4 = 3'h0;
    localparam logic [2:0] IPCB_IDX_CFG_5 = 3'h1;
    localparam logic [2:0] IPCB_IDX_CFG_6 = 3'h2;
    localparam logic [2:0] IPCB_IDX_CFG_7 = 3'h3;
    localparam logic [2:0] IPCB_IDX_CFG_8 = 3'h4;
    localparam logic [2:0] IPCB_IDX_CFG_9 = 3'h5;

    // implemented bits per register, entry 0 is priority_cfg_4
    localparam logic [5:0][15:0] IPCB_IMPL_MASK = {
        16'h7770, 16'h0077, 16'h7777, 16'h7770, 16'h7707, 16'h7777
    };
    // every implemented field resets to 3'b100
    localparam logic [15:0] IPCB_RST_PATTERN = 16'h4444;

    // ****************************************************************
    // field layout and priority codes
    // ****************************************************************
    localparam int IPCB_FLD_W     = 3;
    localparam int IPCB_SLOT3_LSB = 12;
    localparam int IPCB_SLOT2_LSB = 8;
    localparam int IPCB_SLOT1_LSB = 4;
    localparam int IPCB_SLOT0_LSB = 0;
    localparam logic [2:0] IPCB_PRIO_OFF = 3'h0;
    localparam logic [2:0] IPCB_PRIO_MIN = 3'h1;
    localparam logic [2:0] IPCB_PRIO_MAX = 3'h7;

    // source numbering on the flag and request vectors
    localparam int IPCB_SRC_PIN_CHANGE = 0;
    localparam int IPCB_SRC_COMPARATOR = 1;
    localparam int IPCB_SRC_I2C1_MST   = 2;
    localparam int IPCB_SRC_I2C1_SLV   = 3;
    localparam int IPCB_SRC_CAPTURE8   = 4;
    localparam int IPCB_SRC_CAPTURE7   = 5;
    localparam int IPCB_SRC_EXT_IRQ1   = 6;
    localparam int IPCB_SRC_TIMER4     = 7;
    localparam int IPCB_SRC_COMPARE4   = 8;
    localparam int IPCB_SRC_COMPARE3   = 9;
    localparam int IPCB_SRC_UART2_TX   = 10;
    localparam int IPCB_SRC_UART2_RX   = 11;
    localparam int IPCB_SRC_EXT_IRQ2   = 12;
    localparam int IPCB_SRC_TIMER5     = 13;
    localparam int IPCB_SRC_SPI2_EVT   = 14;
    localparam int IPCB_SRC_SPI2_FLT   = 15;
    localparam int IPCB_SRC_CAPTURE5   = 16;
    localparam int IPCB_SRC_CAPTURE4   = 17;
    localparam int IPCB_SRC_CAPTURE3   = 18;

endpackage

/* File: hw/ipcb_reg_if.sv */
`timescale 1ns/100ps
// register access between the bus slave and the register bank
interface ipcb_reg_if;
    import ipcb_pkg::*;
    logic                   wr_en;
    logic [IPCB_ADDR_W-1:0] idx;
    logic [IPCB_REG_W-1:0]  wdata;
    logic [1:0]             be;
    logic [IPCB_REG_W-1:0]  rdata;

    modport slave (output wr_en, output idx, output wdata, output be, input rdata);
    modport bank  (input wr_en, input idx, input wdata, input be, output rdata);
endinterface

/* File: hw/ipcb_avalon_slave.sv */
`timescale 1ns/100ps
module ipcb_avalon_slave
    import ipcb_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire logic                   ce,
    input  wire logic [IPCB_ADDR_W-1:0] avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [IPCB_DATA_W-1:0] avs_writedata,
    input  wire logic [IPCB_BE_W-1:0]   avs_byteenable,
    output logic [IPCB_DATA_W-1:0]      avs_readdata,
    output logic                        avs_waitrequest,
    ipcb_reg_if.slave                   rif
);

    // ****************************************************************
    // two-phase handshake
    // ****************************************************************
    typedef enum logic {IPCB_ST_IDLE, IPCB_ST_ACK} ipcb_state_t;

    ipcb_state_t            state_reg;
    ipcb_state_t            state_next;
    logic [IPCB_REG_W-1:0]  readdata_reg;
    wire                    req_seen;

    // a request is taken one cycle after it appears, so read data is
    // always captured before waitrequest falls
    assign req_seen = avs_read | avs_write;

    always_comb begin
        case (state_reg)
            IPCB_ST_IDLE: state_next = req_seen ? IPCB_ST_ACK : IPCB_ST_IDLE;
            IPCB_ST_ACK:  state_next = IPCB_ST_IDLE;
            default:      state_next = IPCB_ST_IDLE;
        endcase
    end

    // state and read data capture
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg    <= IPCB_ST_IDLE;
            readdata_reg <= 16'h0000;
        end else if (ce) begin
            state_reg <= state_next;
            if (state_reg == IPCB_ST_IDLE && avs_read) begin
                readdata_reg <= rif.rdata;
            end
        end
    end

    // write lands at the edge where waitrequest is seen low
    assign rif.wr_en       = (state_reg == IPCB_ST_ACK) & avs_write & ce;
    assign rif.idx         = avs_address;
    assign rif.wdata       = avs_writedata[IPCB_REG_W-1:0];
    assign rif.be          = avs_byteenable[1:0];
    // a frozen ack cycle would tell the master its write landed when it did not
    assign avs_waitrequest = (state_reg != IPCB_ST_ACK) | ~ce;
    assign avs_readdata    = {16'h0000, readdata_reg};  // upper half always zero

endmodule

/* File: hw/ipcb_bank.sv */
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
module ipcb_bank
    import ipcb_pkg::*;
(
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    // avalon-mm slave
    input  wire logic [IPCB_ADDR_W-1:0]  avs_address,
    input  wire logic                    avs_read,
    input  wire logic                    avs_write,
    input  wire logic [IPCB_DATA_W-1:0]  avs_writedata,
    input  wire logic [IPCB_BE_W-1:0]    avs_byteenable,
    output logic [IPCB_DATA_W-1:0]       avs_readdata,
    output logic                         avs_waitrequest,
    // raw source flags and gated requests
    input  wire logic [IPCB_NUM_SRC-1:0] src_flag,
    output logic [IPCB_NUM_SRC-1:0]      src_req,
    // priority fields towards arbitration
    output logic [2:0]                   pin_change_prio,
    output logic [2:0]                   comparator_prio,
    output logic [2:0]                   i2c_one_master_prio,
    output logic [2:0]                   i2c_one_slave_prio,
    output logic [2:0]                   capture_eight_prio,
    output logic [2:0]                   capture_seven_prio,
    output logic [2:0]                   ext_irq_one_prio,
    output logic [2:0]                   timer_four_prio,
    output logic [2:0]                   compare_four_prio,
    output logic [2:0]                   compare_three_prio,
    output logic [2:0]                   uart_two_tx_prio,
    output logic [2:0]                   uart_two_rx_prio,
    output logic [2:0]                   ext_irq_two_prio,
    output logic [2:0]                   timer_five_prio,
    output logic [2:0]                   spi_two_event_prio,
    output logic [2:0]                   spi_two_fault_prio,
    output logic [2:0]                   capture_five_prio,
    output logic [2:0]                   capture_four_prio,
    output logic [2:0]                   capture_three_prio
);

    // ****************************************************************
    // helpers
    // ****************************************************************

    // true for an index that names one of the six registers
    function automatic logic idx_hit(input logic [IPCB_ADDR_W-1:0] idx);
        idx_hit = (idx < IPCB_ADDR_W'(IPCB_NUM_REGS));
    endfunction

    // a field passes its flag only when its code is non-zero
    function automatic logic prio_enabled(input logic [2:0] code);
        prio_enabled = (code != IPCB_PRIO_OFF);
    endfunction

    // ****************************************************************
    // bus slave
    // ****************************************************************
    ipcb_reg_if rif ();

    ipcb_avalon_slave u_slave (
        .sys_clk         (sys_clk),
        .rst_n           (rst_n),
        .ce              (ce),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .rif             (rif)
    );

    // ****************************************************************
    // register storage
    // ****************************************************************
    logic [IPCB_REG_W-1:0] cfg_reg  [IPCB_NUM_REGS];
    logic [IPCB_REG_W-1:0] cfg_next [IPCB_NUM_REGS];
    wire                   wr_hit;
    wire  [IPCB_REG_W-1:0] lane_mask;

    // unmapped indices are neither written nor read back
    assign wr_hit    = rif.wr_en & idx_hit(rif.idx);
    // byte enables 3 and 2 cover the always-zero upper half
    assign lane_mask = {{8{rif.be[1]}}, {8{rif.be[0]}}};

    genvar gi;
    generate
        for (gi = 0; gi < IPCB_NUM_REGS; gi++) begin : g_reg
            wire [IPCB_REG_W-1:0] keep_mask;
            wire                  sel;

            // only implemented bits in enabled lanes may change
            assign keep_mask = IPCB_IMPL_MASK[gi] & lane_mask;
            assign sel       = wr_hit & (rif.idx == IPCB_ADDR_W'(gi));
            assign cfg_next[gi] = sel ?
                ((rif.wdata & keep_mask) | (cfg_reg[gi] & ~keep_mask)) : cfg_reg[gi];

            // one clocked word per register; ce freezes it
            always_ff @(posedge sys_clk) begin
                if (!rst_n) begin
                    cfg_reg[gi] <= IPCB_RST_PATTERN & IPCB_IMPL_MASK[gi];
                end else if (ce) begin
                    cfg_reg[gi] <= cfg_next[gi] & IPCB_IMPL_MASK[gi];
                end
            end
        end
    endgenerate

    // read mux; unimplemented bits are never stored, so they read zero
    assign rif.rdata = idx_hit(rif.idx) ? cfg_reg[rif.idx] : 16'h0000;

    // ****************************************************************
    // field extraction
    // ****************************************************************
    logic [2:0] fld [IPCB_NUM_SRC];

    // the code is the level itself: 7 highest, 1 lowest, 0 off
    // first register
    assign fld[IPCB_SRC_PIN_CHANGE] =
        cfg_reg[IPCB_IDX_CFG_4][IPCB_SLOT3_LSB +: IPCB_FLD_W];
    assign fld[IPCB_SRC_COMPARATOR] =
        cfg_reg[IPCB_IDX_CFG_4][IPCB_SLOT2_LSB +: IPCB_FLD_W];
    assign fld[IPCB_SRC_I2C1_MST]   =
        cfg_reg[IPCB_IDX_CFG_4][IPCB_SLOT1_LSB +: IPCB_FLD_W];
    assign fld[IPCB_SRC_I2C1_SLV]   =
        cfg_reg[IPCB_IDX_CFG_4][IPCB_SLOT0_LSB +: IPCB_FLD_W];

    // second register, bits 7..3 absent
    assign fld[IPCB_SRC_CAPTURE8]   =
        cfg_reg[IPCB_IDX_CFG_5][IPCB_SLOT3_LSB +: IPCB_FLD_W];
    assign fld[IPCB_SRC_CAPTURE7]   =
        cfg_reg[IPCB_IDX_CFG_5][IPCB_SLOT2_LSB +: IPCB_FLD_W];
    assign fld[IPCB_SRC_EXT_IRQ1]   =
        cfg_reg[IPCB_IDX_CFG_5][IPCB_SLOT0_LSB +: IPCB_FLD_W];

    // third register, bits 3..0 absent
    assign fld[IPCB_SRC_TIMER4]     =
        cfg_reg[IPCB_IDX_CFG_6][IPCB_SLOT3_LSB +: IPCB_FLD_W];
    assign fld[IPCB_SRC_COMPARE4]   =
        cfg_reg[IPCB_IDX_CFG_6][IPCB_SLOT2_LSB +: IPCB_FLD_W];
    assign fld[IPCB_SRC_COMPARE3]   =
        cfg_reg[IPCB_IDX_CFG_6][IPCB_SLOT1_LSB +: IPCB_FLD_W];

    // fourth register, fully populated
    assign fld[IPCB_SRC_UART2_TX]   =
        cfg_reg[IPCB_IDX_CFG_7][IPCB_SLOT3_LSB +: IPCB_FLD_W];
    assign fld[IPCB_SRC_UART2_RX]   =
        cfg_reg[IPCB_IDX_CFG_7][IPCB_SLOT2_LSB +: IPCB_FLD_W];
    assign fld[IPCB_SRC_EXT_IRQ2]   =
        cfg_reg[IPCB_IDX_CFG_7][IPCB_SLOT1_LSB +: IPCB_FLD_W];
    assign fld[IPCB_SRC_TIMER5]     =
        cfg_reg[IPCB_IDX_CFG_7][IPCB_SLOT0_LSB +: IPCB_FLD_W];

    // fifth register, bits 15..7 absent
    assign fld[IPCB_SRC_SPI2_EVT]   =
        cfg_reg[IPCB_IDX_CFG_8][IPCB_SLOT1_LSB +: IPCB_FLD_W];
    assign fld[IPCB_SRC_SPI2_FLT]   =
        cfg_reg[IPCB_IDX_CFG_8][IPCB_SLOT0_LSB +: IPCB_FLD_W];

    // sixth register, bits 3..0 absent
    assign fld[IPCB_SRC_CAPTURE5]   =
        cfg_reg[IPCB_IDX_CFG_9][IPCB_SLOT3_LSB +: IPCB_FLD_W];
    assign fld[IPCB_SRC_CAPTURE4]   =
        cfg_reg[IPCB_IDX_CFG_9][IPCB_SLOT2_LSB +: IPCB_FLD_W];
    assign fld[IPCB_SRC_CAPTURE3]   =
        cfg_reg[IPCB_IDX_CFG_9][IPCB_SLOT1_LSB +: IPCB_FLD_W];

    // ****************************************************************
    // arbitration-facing outputs
    // ****************************************************************

    // straight from the register flops, no extra stage
    assign pin_change_prio     = fld[IPCB_SRC_PIN_CHANGE];
    assign comparator_prio     = fld[IPCB_SRC_COMPARATOR];
    assign i2c_one_master_prio = fld[IPCB_SRC_I2C1_MST];
    assign i2c_one_slave_prio  = fld[IPCB_SRC_I2C1_SLV];
    assign capture_eight_prio  = fld[IPCB_SRC_CAPTURE8];
    assign capture_seven_prio  = fld[IPCB_SRC_CAPTURE7];
    assign ext_irq_one_prio    = fld[IPCB_SRC_EXT_IRQ1];
    assign timer_four_prio     = fld[IPCB_SRC_TIMER4];
    assign compare_four_prio   = fld[IPCB_SRC_COMPARE4];
    assign compare_three_prio  = fld[IPCB_SRC_COMPARE3];
    assign uart_two_tx_prio    = fld[IPCB_SRC_UART2_TX];
    assign uart_two_rx_prio    = fld[IPCB_SRC_UART2_RX];
    assign ext_irq_two_prio    = fld[IPCB_SRC_EXT_IRQ2];
    assign timer_five_prio     = fld[IPCB_SRC_TIMER5];
    assign spi_two_event_prio  = fld[IPCB_SRC_SPI2_EVT];
    assign spi_two_fault_prio  = fld[IPCB_SRC_SPI2_FLT];
    assign capture_five_prio   = fld[IPCB_SRC_CAPTURE5];
    assign capture_four_prio   = fld[IPCB_SRC_CAPTURE4];
    assign capture_three_prio  = fld[IPCB_SRC_CAPTURE3];

    // ****************************************************************
    // request gating
    // ****************************************************************
    logic [IPCB_NUM_SRC-1:0] src_req_reg;
    wire  [IPCB_NUM_SRC-1:0] src_req_next;

    // a disabled source is blocked however long its flag stays high;
    // registering costs one cycle but keeps the output glitch free
    generate
        for (gi = 0; gi < IPCB_NUM_SRC; gi++) begin : g_req
            assign src_req_next[gi] = src_flag[gi] & prio_enabled(fld[gi]);
        end
    endgenerate

    // request flops
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            src_req_reg <= 19'h00000;
        end else if (ce) begin
            src_req_reg <= src_req_next;
        end
    end

    assign src_req = src_req_reg;

endmodule

/* File: verif/ipcb_bank_asserts.sv */
`timescale 1ns/100ps
module ipcb_bank_asserts
    import ipcb_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic [2:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [18:0] src_flag,
    input wire logic [18:0] src_req,
    input wire logic [2:0]  pin_change_prio,
    input wire logic [2:0]  comparator_prio,
    input wire logic [2:0]  spi_two_fault_prio
);
    // ****************************************************************
    // readable bits of the addressed word
    // ****************************************************************
    logic [31:0] rd_mask;
    // unmapped words expose no bits at all
    assign rd_mask = (avs_address < 3'h6) ? {16'h0, IPCB_IMPL_MASK[avs_address]} : 32'h0;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence req_rise;
        ce && $rose(avs_read || avs_write);
    endsequence
    sequence acked_wr(logic [2:0] idx);
        ce && avs_write && !avs_waitrequest && avs_address == idx;
    endsequence

    one_wait_a: assert property (req_rise |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after exactly one wait cycle");
    idle_wait_a: assert property (ce && !avs_read && !avs_write |-> avs_waitrequest)
        else $error("waitrequest low without a request");
    read_mask_a: assert property (
        ce && avs_read && !avs_waitrequest |-> (avs_readdata & ~rd_mask) == 32'h0)
        else $error("unimplemented bit read as one");
    wr_field_a: assert property (
        acked_wr(IPCB_IDX_CFG_4) && avs_byteenable[1]
        |=> pin_change_prio == $past(avs_writedata[14:12]))
        else $error("written field not presented next cycle");
    lane_keep_a: assert property (
        acked_wr(IPCB_IDX_CFG_4) && !avs_byteenable[1] |=> $stable(pin_change_prio))
        else $error("disabled byte lane changed a field");
    spi_wr_a: assert property (
        acked_wr(IPCB_IDX_CFG_8) && avs_byteenable[0]
        |=> spi_two_fault_prio == $past(avs_writedata[2:0]))
        else $error("fault field not at bits 2 to 0");
    gate_off_a: assert property (
        ce && comparator_prio == IPCB_PRIO_OFF |=> !src_req[IPCB_SRC_COMPARATOR])
        else $error("disabled source still requests");
    // the edge that releases reset still applies it, so start only once out of reset
    req_track_a: assert property (ce && rst_n |=> src_req[IPCB_SRC_PIN_CHANGE] ==
        ($past(src_flag[IPCB_SRC_PIN_CHANGE]) && $past(pin_change_prio) != 3'h0))
        else $error("request does not follow flag and field");
    freeze_a: assert property (!ce |=> $stable(src_req) && $stable(pin_change_prio))
        else $error("state moved while clock enable low");
    reset_val_a: assert property ($rose(rst_n) && $past(ce) |->
        pin_change_prio == 3'h4 && spi_two_fault_prio == 3'h4 && src_req == 19'h0)
        else $error("field not at level four after reset");
endmodule

bind ipcb_bank ipcb_bank_asserts u_chk (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .src_flag(src_flag), .src_req(src_req),
    .pin_change_prio(pin_change_prio), .comparator_prio(comparator_prio),
    .spi_two_fault_prio(spi_two_fault_prio)
);

/* File: verif/tb_ipcb_bank.sv */
`timescale 1ns/100ps
module tb_ipcb_bank;
    import ipcb_pkg::*;
    logic        sys_clk;
    logic        rst_n;
    logic        ce;
    logic [2:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [18:0] src_flag;
    logic [18:0] src_req;
    wire  [56:0] prio_seen;
    logic [18:0] req_pend;
    logic [15:0] mirror [6];
    logic [31:0] exp_q [$];
    logic [15:0] pats [4];
    logic        chk_on;
    int          error_cnt;
    int          n_compared;
    int          seed;

    ipcb_bank dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .src_flag(src_flag), .src_req(src_req),
        .pin_change_prio(prio_seen[56:54]), .comparator_prio(prio_seen[53:51]),
        .i2c_one_master_prio(prio_seen[50:48]), .i2c_one_slave_prio(prio_seen[47:45]),
        .capture_eight_prio(prio_seen[44:42]), .capture_seven_prio(prio_seen[41:39]),
        .ext_irq_one_prio(prio_seen[38:36]), .timer_four_prio(prio_seen[35:33]),
        .compare_four_prio(prio_seen[32:30]), .compare_three_prio(prio_seen[29:27]),
        .uart_two_tx_prio(prio_seen[26:24]), .uart_two_rx_prio(prio_seen[23:21]),
        .ext_irq_two_prio(prio_seen[20:18]), .timer_five_prio(prio_seen[17:15]),
        .spi_two_event_prio(prio_seen[14:12]), .spi_two_fault_prio(prio_seen[11:9]),
        .capture_five_prio(prio_seen[8:6]), .capture_four_prio(prio_seen[5:3]),
        .capture_three_prio(prio_seen[2:0])
    );

    // ****************************************************************
    // expectation helpers
    // ****************************************************************
    // fields in source order, source 0 in the top bits
    function automatic logic [56:0] fvec();
        fvec = {mirror[0][14:12], mirror[0][10:8], mirror[0][6:4], mirror[0][2:0],
                mirror[1][14:12], mirror[1][10:8], mirror[1][2:0],
                mirror[2][14:12], mirror[2][10:8], mirror[2][6:4],
                mirror[3][14:12], mirror[3][10:8], mirror[3][6:4], mirror[3][2:0],
                mirror[4][6:4], mirror[4][2:0],
                mirror[5][14:12], mirror[5][10:8], mirror[5][6:4]};
    endfunction

    // a zero field blocks its source
    function automatic logic [18:0] nz(input logic [56:0] v);
        for (int i = 0; i < 19; i++) nz[i] = |v[56-3*i -: 3];
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // one avalon transfer; the request stands until waitrequest is seen low
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        logic [15:0] m;
        int          n;
        n = 0;
        m = {{8{be[1]}}, {8{be[0]}}};
        @(posedge sys_clk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        if (!wr) exp_q.push_back((a < 3'h6) ? {16'h0, mirror[a]} : 32'h0);
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        check(64'(n < 50), 64'h1);
        if (wr && a < 3'h6) mirror[a] = ((mirror[a] & ~m) | (d[15:0] & m)) & IPCB_IMPL_MASK[a];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic reset_mirror();
        for (int i = 0; i < 6; i++) mirror[i] = IPCB_RST_PATTERN & IPCB_IMPL_MASK[i];
    endtask

    // ****************************************************************
    // clock, flags, watchdog and output monitor
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) src_flag <= 19'($random(seed));

    // whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        end_of_test();
    end

    // read data is taken at the ack edge, the rest once that edge has landed
    always @(posedge sys_clk) begin
        if ((avs_read && !avs_waitrequest) === 1'b1)
            check(64'(avs_readdata), 64'(exp_q.pop_front()));
        #1;
        if (chk_on) begin
            check(64'(prio_seen), 64'(fvec()));
            check(64'(src_req), 64'(req_pend));
        end
        if (ce) req_pend = src_flag & nz(fvec());
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {rst_n, avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = '0;
        {src_flag, req_pend, chk_on, error_cnt, n_compared} = '0;
        ce = 1'b1;
        seed = 32'h49e38774;
        pats = '{16'h7777, 16'h1111, 16'h0000, 16'hF235};
        reset_mirror();
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk_on = 1'b1;
        for (int a = 0; a < 8; a++) bus(1'b0, 3'(a), 32'h0, 4'hF);
        // top, bottom, off and a distinct code per slot
        foreach (pats[p]) for (int a = 0; a < 8; a++) begin
            bus(1'b1, 3'(a), {16'hFFFF, pats[p]}, 4'hF);
            bus(1'b0, 3'(a), 32'h0, 4'hF);
        end
        repeat (120) bus(1'($random(seed)), 3'($random(seed)), $random(seed),
                         4'($random(seed)));
        // frozen clock enable while the flags keep moving
        ce <= 1'b0;
        repeat (10) @(posedge sys_clk);
        ce <= 1'b1;
        // second reset in mid-run
        @(posedge sys_clk);
        chk_on = 1'b0;
        rst_n <= 1'b0;
        reset_mirror();
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk_on = 1'b1;
        for (int a = 0; a < 6; a++) bus(1'b0, 3'(a), 32'h0, 4'hF);
        repeat (3) @(posedge sys_clk);
        end_of_test();
    end
endmodule
